// [src/scs_pkg.sv]
// package for the subcode and sense readout block: offsets, reset values, counts, modes
// assumes a 250 MHz system clock and a classic wishbone register bus with 32-bit data
package scs_pkg;

    // timing
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned MONO_MAX_US   = 400;                   // longest hold-off time
    localparam int unsigned MONO_CYCLES   = MONO_MAX_US * CLK_MHZ; // rounded down, exact here

    // register byte offsets
    localparam logic [7:0] ADR_CMD        = 8'h00;
    localparam logic [7:0] ADR_STATUS     = 8'h04;
    localparam logic [7:0] ADR_MASK       = 8'h08;
    localparam logic [7:0] ADR_LIVE       = 8'h0c;

    // reset values
    localparam logic [7:0] CMD_RST        = 8'h00;
    localparam logic [2:0] MASK_RST       = 3'h0;
    localparam logic [1:0] SEL_RST        = 2'h0;

    // status bit positions (sticky, write one to clear)
    localparam int unsigned ST_LOADED     = 0;
    localparam int unsigned ST_CRC_FAIL   = 1;
    localparam int unsigned ST_SYNC       = 2;

    // command nibbles
    localparam logic [3:0] NIB_BUSY       = 4'h4;
    localparam logic [3:0] NIB_FOCUS      = 4'h5;
    localparam logic [3:0] NIB_SERVO6     = 4'h6;
    localparam logic [3:0] NIB_FSYNC      = 4'ha;
    localparam logic [3:0] NIB_SERIAL_BUS = 4'hb;
    localparam logic [3:0] NIB_OVERLEN    = 4'he;
    localparam int unsigned SEL_HI_POS    = 3;
    localparam int unsigned SEL_LO_POS    = 2;

    // subcode framing
    localparam int unsigned PW_BITS       = 8;
    localparam int unsigned Q_BIT_POS     = 6;    // P is bit 7, Q bit 6 of the symbol
    localparam int unsigned Q_DATA_BITS   = 80;
    localparam int unsigned Q_BITS        = 96;
    localparam logic [6:0]  Q_CNT_DATA    = 7'h50;
    localparam logic [6:0]  Q_CNT_FULL    = 7'h60;
    localparam logic [6:0]  Q_CNT_IDLE    = 7'h61;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [15:0] CRC_INIT      = 16'h0000;

    // output path of the sub q serial pin, one-hot
    typedef enum logic [3:0] {
        SQ_QDATA = 4'b0001,
        SQ_PW    = 4'b0010,
        SQ_SENSE = 4'b0100,
        SQ_MUX   = 4'b1000
    } scs_subq_serial_out_mode_t;

    // one step of the sub q crc, msb first
    function automatic logic [15:0] scs_crc_step(input logic [15:0] crc, input logic bit_in);
        logic fb;
        fb = crc[15] ^ bit_in;
        scs_crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    endfunction

endpackage

// [src/scs_sync2.sv]
// two flip-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level or a clock far below the system clock
`timescale 1ns/1ns
module scs_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } scs_sync_state_t;

    scs_sync_state_t st_r;
    scs_sync_state_t st_nxt;

    // first stage is read only by the second stage
    always_comb begin
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule

// [src/scs_subq_ps.sv]
// 80-bit parallel/serial register for sub q readout
// assumes load and shift are one-cycle pulses on the system clock, load wins
`timescale 1ns/1ns
module scs_subq_ps #(
    parameter int unsigned BITS = scs_pkg::Q_DATA_BITS
) (
    input  wire logic            clk_in,
    input  wire logic            rst_b_in,
    input  wire logic            load_in,
    input  wire logic [BITS-1:0] data_in,
    input  wire logic            shift_in,
    output logic                 bit_out
);

    typedef struct packed {
        logic [BITS-1:0] sh;
    } scs_ps_state_t;

    scs_ps_state_t st_r;
    scs_ps_state_t st_nxt;
    logic [BITS-1:0] rev;

    // swap bit order inside each byte, byte order kept, so each byte leaves lsb first
    always_comb begin
        rev = '0;
        for (int i = 0; i < BITS; i++) begin
            rev[(i / 8) * 8 + (7 - (i % 8))] = data_in[i];
        end
    end

    // load, else shift towards the output at the top bit
    always_comb begin
        st_nxt = st_r;
        if (load_in) begin
            st_nxt.sh = rev;
        end else if (shift_in) begin
            st_nxt.sh = {st_r.sh[BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bit_out = st_r.sh[BITS-1];

endmodule

// [src/scs_top.sv]
// subcode and sense readout: sense selector, p-w and sub q serial readout, wishbone regs
// assumes subcode symbols, frame clock and subcode sync come from logic on clk_in;
// sense pins and host read clocks are asynchronous and are synchronised here
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module scs_top #(
    parameter int unsigned MONO_CYCLES_P = scs_pkg::MONO_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    input  wire logic        servo_sense_in,
    input  wire logic        seq_busy_n_in,
    input  wire logic        focus_ok_in,
    input  wire logic        frame_sync_good_in,
    input  wire logic        efm_overlength_n_in,
    input  wire logic [7:0]  subcode_sym_in,
    input  wire logic        frame_clock_in,
    input  wire logic        subcode_sync_in,
    input  wire logic        subcode_pw_clock_in,
    input  wire logic        subq_read_clock_in,
    output logic             write_frame_clock_out,
    output logic             subcode_sync_out,
    output logic             subcode_pw_serial_out,
    output logic             subq_serial_out,
    output logic             status_sense_out,
    output logic             crc_ok_flag_out
);

    localparam int unsigned MCW = $clog2(MONO_CYCLES_P + 1);
    localparam logic [MCW-1:0] MONO_LOAD = MCW'(MONO_CYCLES_P);

    typedef struct packed {
        logic [7:0]              cmd;
        logic [1:0]              sel;
        logic [2:0]              stat;
        logic [2:0]              mask;
        logic                    ack;
        logic [31:0]             rdat;
        logic                    write_frame_clock_prev;
        logic                    subcode_pw_clock_prev;
        logic                    subq_read_clock_prev;
        logic [MCW-1:0]          mono;
        logic [7:0]              pw_sh;
        logic [6:0]              q_cnt;
        logic [15:0]             crc;
        logic [15:0]             chk;
        logic [scs_pkg::Q_DATA_BITS-1:0] sp;
        logic                    crc_ok;
        logic                    show_crc;
        logic [1:0]              mux_idx;
    } scs_state_t;

    scs_state_t st_r;
    scs_state_t st_nxt;

    logic [6:0]               syn;
    logic                     servo_s;
    logic                     busy_s;
    logic                     focus_s;
    logic                     fsync_s;
    logic                     ovl_s;
    logic                     subcode_pw_clock_s;
    logic                     subq_read_clock_s;
    logic                     frame_fall;
    logic                     subcode_pw_clock_rise;
    logic                     subq_read_clock_rise;
    logic                     held;
    logic                     q_eval;
    logic                     crc_pass;
    logic                     ps_load;
    logic                     ps_shift;
    logic                     ps_bit;
    logic                     sense;
    logic                     pw_clk;
    logic                     wb_req;
    logic                     wb_wr;
    logic                     q_bit;
    scs_pkg::scs_subq_serial_out_mode_t  mode;

    // sense pins and host clocks cross into clk_in
    scs_sync2 #(
        .WIDTH (7)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in ({subq_read_clock_in, subcode_pw_clock_in, efm_overlength_n_in,
                    frame_sync_good_in, focus_ok_in, seq_busy_n_in, servo_sense_in}),
        .sync_out (syn)
    );

    assign {subq_read_clock_s, subcode_pw_clock_s, ovl_s, fsync_s, focus_s, busy_s, servo_s} = syn;

    // sense selector, straight from the latest command nibble
    always_comb begin
        unique case (st_r.cmd[7:4])
            4'h0, 4'h1, 4'h2, 4'h3, scs_pkg::NIB_SERVO6: sense = servo_s;
            scs_pkg::NIB_BUSY:                          sense = busy_s;
            scs_pkg::NIB_FOCUS:                         sense = focus_s;
            scs_pkg::NIB_FSYNC:                         sense = fsync_s;
            scs_pkg::NIB_OVERLEN:                       sense = ovl_s;
            default:                                    sense = 1'b0;
        endcase
    end

    // edges, hold-off and sub q path decode
    always_comb begin
        frame_fall = st_r.write_frame_clock_prev && !frame_clock_in;
        subcode_pw_clock_rise  = subcode_pw_clock_s && !st_r.subcode_pw_clock_prev;
        subq_read_clock_rise  = subq_read_clock_s && !st_r.subq_read_clock_prev;
        held       = (st_r.mono != '0);
        q_eval     = (st_r.q_cnt == scs_pkg::Q_CNT_FULL);
        crc_pass   = (st_r.crc == ~st_r.chk);
        ps_load    = q_eval && crc_pass && !held;
        unique case (st_r.sel)
            2'b01:   mode = scs_pkg::SQ_PW;
            2'b10:   mode = scs_pkg::SQ_SENSE;
            2'b11:   mode = scs_pkg::SQ_MUX;
            default: mode = scs_pkg::SQ_QDATA;
        endcase
        pw_clk     = (mode == scs_pkg::SQ_PW) ? subq_read_clock_rise : subcode_pw_clock_rise;
        ps_shift   = (mode == scs_pkg::SQ_QDATA) && subq_read_clock_rise && !st_r.show_crc;
        q_bit      = subcode_sym_in[scs_pkg::Q_BIT_POS];
        wb_req     = wb_cyc_in && wb_stb_in;
        wb_wr      = wb_req && wb_we_in && st_r.ack && wb_sel_in[0];
    end

    // next state of the whole block
    always_comb begin
        st_nxt           = st_r;
        st_nxt.write_frame_clock_prev = frame_clock_in;
        st_nxt.subcode_pw_clock_prev = subcode_pw_clock_s;
        st_nxt.subq_read_clock_prev = subq_read_clock_s;

        // retriggerable hold-off: held while read clock is low, runs down while high
        if (!subq_read_clock_s) begin
            st_nxt.mono = MONO_LOAD;
        end else if (held) begin
            st_nxt.mono = st_r.mono - MCW'(1);
        end

        // p-w symbol taken at frame clock fall, shifted by the chosen clock
        if (frame_fall) begin
            st_nxt.pw_sh = subcode_sym_in;
        end else if (pw_clk) begin
            st_nxt.pw_sh = {st_r.pw_sh[6:0], 1'b0};
        end

        // q bit collection, one bit per frame
        if (subcode_sync_in) begin
            st_nxt.q_cnt = '0;
            st_nxt.crc   = scs_pkg::CRC_INIT;
        end else if (frame_fall && st_r.q_cnt < scs_pkg::Q_CNT_FULL) begin
            if (st_r.q_cnt < scs_pkg::Q_CNT_DATA) begin
                st_nxt.sp  = {st_r.sp[scs_pkg::Q_DATA_BITS-2:0], q_bit};
                st_nxt.crc = scs_pkg::scs_crc_step(st_r.crc, q_bit);
            end else begin
                st_nxt.chk = {st_r.chk[14:0], q_bit};
            end
            st_nxt.q_cnt = st_r.q_cnt + 7'h01;
        end else if (q_eval) begin
            st_nxt.q_cnt  = scs_pkg::Q_CNT_IDLE;
        end

        // verdict and flag stand even when a new sync lands in the evaluation cycle
        if (q_eval) begin
            st_nxt.crc_ok = crc_pass;
            if (ps_load) begin
                st_nxt.show_crc = 1'b1;
            end
        end

        // first read clock after a load moves the pin from flag to data
        if (subq_read_clock_rise && st_r.show_crc && !ps_load) begin
            st_nxt.show_crc = 1'b0;
        end

        // multiplex index for select 1,1; restarts once the hold-off runs out
        if (!held) begin
            st_nxt.mux_idx = 2'h0;
        end else if (subq_read_clock_rise && mode == scs_pkg::SQ_MUX) begin
            st_nxt.mux_idx = st_r.mux_idx + 2'h1;
        end

        // wishbone: registered ack, write and read data at the acked edge
        st_nxt.ack  = wb_req && !st_r.ack;
        st_nxt.rdat = 32'h0000_0000;
        if (wb_req && !st_r.ack && !wb_we_in) begin
            unique case (wb_adr_in)
                scs_pkg::ADR_CMD:    st_nxt.rdat = {24'h000000, st_r.cmd};
                scs_pkg::ADR_STATUS: st_nxt.rdat = {29'h0, st_r.stat};
                scs_pkg::ADR_MASK:   st_nxt.rdat = {29'h0, st_r.mask};
                scs_pkg::ADR_LIVE:   st_nxt.rdat = {26'h0, st_r.sel, held, st_r.crc_ok,
                                                    st_r.show_crc, sense};
                default:             st_nxt.rdat = 32'h0000_0000;
            endcase
        end
        if (wb_wr && wb_adr_in == scs_pkg::ADR_CMD) begin
            st_nxt.cmd = wb_dat_in[7:0];
            if (wb_dat_in[7:4] == scs_pkg::NIB_SERIAL_BUS) begin
                st_nxt.sel = {wb_dat_in[scs_pkg::SEL_HI_POS], wb_dat_in[scs_pkg::SEL_LO_POS]};
            end
        end
        if (wb_wr && wb_adr_in == scs_pkg::ADR_MASK) begin
            st_nxt.mask = wb_dat_in[2:0];
        end
        // sticky events, set wins over a write-one clear in the same cycle
        if (wb_wr && wb_adr_in == scs_pkg::ADR_STATUS) begin
            st_nxt.stat = st_r.stat & ~wb_dat_in[2:0];
        end
        if (ps_load) begin
            st_nxt.stat[scs_pkg::ST_LOADED] = 1'b1;
        end
        if (q_eval && !crc_pass) begin
            st_nxt.stat[scs_pkg::ST_CRC_FAIL] = 1'b1;
        end
        if (subcode_sync_in) begin
            st_nxt.stat[scs_pkg::ST_SYNC] = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r      <= '0;
            st_r.cmd  <= scs_pkg::CMD_RST;
            st_r.sel  <= scs_pkg::SEL_RST;
            st_r.mask <= scs_pkg::MASK_RST;
            st_r.q_cnt <= scs_pkg::Q_CNT_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // readout register, bit order reversed inside each byte on load, byte order kept
    scs_subq_ps #(
        .BITS (scs_pkg::Q_DATA_BITS)
    ) u_ps (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .load_in  (ps_load),
        .data_in  (st_r.sp),
        .shift_in (ps_shift),
        .bit_out  (ps_bit)
    );

    // output pins
    always_comb begin
        unique case (mode)
            scs_pkg::SQ_PW:    subq_serial_out = st_r.pw_sh[7];
            scs_pkg::SQ_SENSE: subq_serial_out = sense;
            scs_pkg::SQ_MUX: begin
                unique case (st_r.mux_idx)
                    2'h0:    subq_serial_out = st_r.crc_ok;
                    2'h1:    subq_serial_out = sense;
                    2'h2:    subq_serial_out = subcode_sync_in;
                    default: subq_serial_out = st_r.pw_sh[7];
                endcase
            end
            default:           subq_serial_out = st_r.show_crc ? st_r.crc_ok : ps_bit;
        endcase
    end

    assign status_sense_out      = sense;
    assign subcode_pw_serial_out = st_r.pw_sh[7];
    assign write_frame_clock_out = st_r.write_frame_clock_prev;
    assign subcode_sync_out      = subcode_sync_in;
    assign crc_ok_flag_out       = st_r.crc_ok;
    assign wb_ack_out            = st_r.ack;
    assign wb_dat_out            = st_r.rdat;
    assign irq_out               = |(st_r.stat & st_r.mask);

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_sense_servo: assert property (st_r.cmd[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h6} |-> status_sense_out == servo_s) else $error("sense not servo");
    a_sense_busy: assert property (st_r.cmd[7:4] == 4'h4 |-> status_sense_out == busy_s) else $error("sense not busy");
    a_sense_focus: assert property (st_r.cmd[7:4] == 4'h5 |-> status_sense_out == focus_s) else $error("sense not focus");
    a_sense_fsync: assert property (st_r.cmd[7:4] == 4'ha |-> status_sense_out == fsync_s) else $error("sense not sync");
    a_sense_ovl: assert property (st_r.cmd[7:4] == 4'he |-> status_sense_out == ovl_s) else $error("sense not ovl");
    a_sense_low: assert property (st_r.cmd[7:4] inside {4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'hf} |-> !status_sense_out) else $error("sense not low");
    a_subq_serial_out_sense: assert property (st_r.sel == 2'b10 |-> subq_serial_out == status_sense_out) else $error("subq_serial_out not sense");
    a_pw_shift: assert property (pw_clk && !frame_fall |=> subcode_pw_serial_out == $past(st_r.pw_sh[6])) else $error("pw shift lost");
    a_subq_serial_out_pw: assert property (st_r.sel == 2'b01 |-> subq_serial_out == subcode_pw_serial_out) else $error("subq_serial_out not pw");
    a_q_collect: assert property (frame_fall && !subcode_sync_in && st_r.q_cnt < 7'h50 |=> st_r.sp[0] == $past(q_bit) && st_r.q_cnt == $past(st_r.q_cnt) + 7'h01) else $error("q bit lost");
    a_crc_load: assert property (q_eval && crc_pass && !held |=> st_r.crc_ok && st_r.show_crc ##1 subq_serial_out || st_r.sel != 2'b00) else $error("crc pass not shown");
    a_mono_hold: assert property (!subq_read_clock_s |=> held [*2] or !subq_read_clock_s) else $error("hold-off not restarted");
    a_no_reload: assert property (held && !st_r.stat[scs_pkg::ST_LOADED] |=> !st_r.stat[scs_pkg::ST_LOADED]) else $error("reload while held");

endmodule

// [tb/scs_host_model.sv]
// host side model: makes the p-w and sub q read clocks
// assumes the bench calls pulse() and samples the outputs between calls
`timescale 1ns/1ns
module scs_host_model (
    output logic pw_clk_out,
    output logic sq_clk_out
);
    // idle levels: clocks stand still between reads
    initial begin
        pw_clk_out = 1'b0;
        sq_clk_out = 1'b1;
    end
    // one 40 ns low phase, then a rising edge; returns mid high phase
    task automatic pulse(input logic sq);
        #1;
        if (sq) sq_clk_out = 1'b0;
        else pw_clk_out = 1'b0;
        #40;
        if (sq) sq_clk_out = 1'b1;
        else pw_clk_out = 1'b1;
        #30;
    endtask
    // park the sub q clock low to keep the hold-off restarted
    task automatic hold_low(input logic lo);
        #1;
        sq_clk_out = !lo;
    endtask
endmodule

// [tb/tb_scs_top.sv]
// self-checking bench for the subcode and sense readout block
// assumes a short hold-off parameter; expected results queue up and a monitor pops them
`timescale 1ns/1ns
module tb_scs_top;
    typedef struct {logic [31:0] m; logic [31:0] v;} scs_note_t;
    logic        clk_in, rst_b_in, cyc, stb, we, look, fclk, sync;
    logic        ack, irq, sense, sq_out, crc_ok, pw_out, pw_clk, sq_clk;
    logic        write_frame_clock_o, sync_o;
    logic [4:0]  pins_in;
    logic [7:0]  adr, sym, s;
    logic [31:0] wdat, rdat;
    logic [79:0] qd;
    logic        e;
    int          errors, checks_done;
    scs_note_t   notes[$];

    scs_top #(.MONO_CYCLES_P(200)) uut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq),
        .servo_sense_in(pins_in[4]), .seq_busy_n_in(pins_in[3]), .focus_ok_in(pins_in[2]),
        .frame_sync_good_in(pins_in[1]), .efm_overlength_n_in(pins_in[0]),
        .subcode_sym_in(sym), .frame_clock_in(fclk), .subcode_sync_in(sync),
        .subcode_pw_clock_in(pw_clk), .subq_read_clock_in(sq_clk),
        .write_frame_clock_out(write_frame_clock_o), .subcode_sync_out(sync_o),
        .subcode_pw_serial_out(pw_out),
        .subq_serial_out(sq_out), .status_sense_out(sense), .crc_ok_flag_out(crc_ok));
    scs_host_model host (.pw_clk_out(pw_clk), .sq_clk_out(sq_clk));

    // 250 mhz clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic tally_and_finish();
        errors += notes.size(); // expected results never seen
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic take(input logic [31:0] seen);
        scs_note_t n;
        if (notes.size() == 0) begin
            errors++;
            $display("mismatch at %0t: result with no note", $time);
        end else begin
            n = notes.pop_front();
            check(seen & n.m, n.v);
        end
    endtask

    // watch read acks and sampling strobes, compare with the oldest note
    always @(posedge clk_in) begin
        if (ack === 1'b1 && we === 1'b0) take(rdat);
        if (look === 1'b1) take({25'h0, sync_o, write_frame_clock_o, sense, sq_out, crc_ok, pw_out, irq});
    end

    // pin snapshot: bit6 sync out, bit5 frame clock out, bit4 sense, bit3 sub q pin,
    // bit2 crc flag, bit1 p-w pin, bit0 irq
    task automatic peek(input logic [31:0] m, input logic [31:0] v);
        notes.push_back('{m, v});
        @(posedge clk_in);
        look <= 1'b1;
        @(posedge clk_in);
        look <= 1'b0;
    endtask

    // classic wishbone single cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            tally_and_finish();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        notes.push_back('{32'hffffffff, v});
        wb(1'b0, a, 32'h0);
    endtask

    task automatic frame(input logic [7:0] v);
        @(posedge clk_in);
        fclk <= 1'b1;
        sym <= v;
        peek(32'h20, 32'h20);
        fclk <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    // one subcode block: sync, 80 data bits msb first, 16 inverted crc bits
    task automatic qblk(input logic [79:0] d, input logic good);
        logic [15:0] c;
        logic [95:0] q;
        logic [7:0]  v;
        c = 16'h0000;
        for (int i = 79; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? scs_pkg::CRC_POLY : 16'h0000);
        q = {d, ~c ^ {15'h0, !good}};
        @(posedge clk_in);
        sync <= 1'b1;
        peek(32'h40, 32'h40);
        sync <= 1'b0;
        for (int i = 95; i >= 0; i--) begin
            v = 8'($urandom);
            v[6] = q[i];
            frame(v);
        end
    endtask

    function automatic logic want(int n, logic [4:0] p);
        case (n)
            0, 1, 2, 3, 6: want = p[4];
            4: want = p[3];
            5: want = p[2];
            10: want = p[1];
            14: want = p[0];
            default: want = 1'b0;
        endcase
    endfunction

    // main sequence
    initial begin
        void'($urandom(49405));
        {rst_b_in, cyc, stb, we, look, fclk, sync} = 7'h0;
        {adr, sym, wdat, pins_in, errors, checks_done} = '0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        wb(1'b1, scs_pkg::ADR_MASK, 32'h1);
        rd(8'h10, 32'h0);
        wb(1'b1, scs_pkg::ADR_CMD, 32'hb8);
        for (int n = 0; n < 16; n++) begin
            pins_in <= 5'($urandom);
            wb(1'b1, scs_pkg::ADR_CMD, {24'h0, 4'(n), 4'h0});
            repeat (4) @(posedge clk_in);
            e = want(n, pins_in);
            peek(n < 11 ? 32'h18 : 32'h10, {27'h0, e, e & (n < 11), 3'h0});
        end
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, scs_pkg::ADR_CMD, m ? 32'hb4 : 32'hb0);
            s = 8'($urandom);
            frame(s);
            for (int b = 7; b >= 0; b--) begin
                if (b < 7) host.pulse(m[0]);
                peek(m ? 32'h8 : 32'h2, {28'h0, s[b] & m[0], 1'b0, s[b] & !m[0], 1'b0});
            end
        end
        wb(1'b1, scs_pkg::ADR_CMD, 32'hb0);
        rd(scs_pkg::ADR_CMD, 32'hb0);
        qd = 80'({$urandom, $urandom, $urandom});
        qblk(qd, 1'b1);
        peek(32'hd, 32'hd);
        rd(scs_pkg::ADR_LIVE, 32'h6);
        for (int i = 0; i < 80; i++) begin
            host.pulse(1'b1);
            peek(32'h8, {28'h0, qd[79 - (8 * (i / 8) + 7 - i % 8)], 3'h0});
        end
        wb(1'b1, scs_pkg::ADR_STATUS, 32'h7);
        host.hold_low(1'b1);
        qblk(~qd, 1'b1);
        host.hold_low(1'b0);
        rd(scs_pkg::ADR_STATUS, 32'h4);
        peek(32'h1, 32'h0);
        repeat (300) @(posedge clk_in);
        qblk(qd, 1'b0);
        peek(32'h4, 32'h0);
        rd(scs_pkg::ADR_STATUS, 32'h6);
        repeat (2) @(posedge clk_in);
        tally_and_finish();
    end
endmodule
